//--- pkg/pbs_pkg.sv
package pbs_pkg;
  localparam int NPORT = 5;
  // register word indices (printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it)
  localparam logic [7:0] IDX_GCTRL2 = 8'h02;
  localparam logic [7:0] IDX_GCTRL3 = 8'h03;
  localparam logic [7:0] IDX_GCTRL4 = 8'h04;
  localparam logic [7:0] IDX_STORM6 = 8'h06;
  localparam logic [7:0] IDX_STORM7 = 8'h07;
  localparam logic [7:0] IDX_PORT_BASE = 8'h10;
  localparam logic [7:0] IDX_PORT_STEP = 8'h10;
  localparam logic [7:0] IDX_PSTAT_OFS = 8'h0E;
  localparam logic [7:0] IDX_CP_FIRST = 8'h60;
  localparam logic [7:0] IDX_CP_LAST = 8'h67;
  // field positions
  localparam int G3_AGGR_BIT = 0;
  localparam int G4_NODROP_BIT = 3;
  localparam int G4_BP_BIT = 5;
  localparam int G4_MCAST_BIT = 6;
  localparam int G2_BASE_LSB = 4;
  localparam int P_STORM_BIT = 7;
  localparam int P_CP_BIT = 6;
  localparam int P_TAG_BIT = 5;
  localparam int P_PRIO_BIT = 4;
  localparam int P_HALF_BIT = 1;
  localparam int P_FAST_BIT = 2;
  // reset values
  localparam logic [7:0] G2_RST = 8'h00;
  localparam logic [7:0] G3_RST = 8'h00;
  localparam logic [7:0] G4_RST = 8'h00;
  localparam logic [10:0] STORM_RST = 11'h04A;
  localparam logic [7:0] PCTRL_RST = 8'h04;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int IVL_FAST_MS = 50;
  localparam int IVL_SLOW_MS = 500;
  localparam int IVL_FAST_CYC = IVL_FAST_MS * CLK_MHZ * 1000;
  localparam int IVL_SLOW_CYC = IVL_SLOW_MS * CLK_MHZ * 1000;
  localparam int CRS_ON_US = 100;
  localparam int CRS_ON_CYC = CRS_ON_US * CLK_MHZ;
  localparam int CRS_GAP_NS = 160;
  localparam int CRS_GAP_CYC = (CRS_GAP_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    PBS_IDLE = 2'b00, PBS_JAM = 2'b01, PBS_GAP = 2'b11, PBS_SEND = 2'b10
  } pbs_state_t;
endpackage : pbs_pkg

//--- verilog/pbs_port_ctrl.sv
// Operation
// RULE_01: backpressure follows full-duplex pause conditions
// RULE_02: send preamble while backpressure required
// RULE_03: drop carrier briefly after bounded time
// RULE_04: queued frames interrupt carrier backpressure
// RULE_05: resume backpressure until resources free
// RULE_06: collision skips backoff, carrier regenerated now
// RULE_07: aggressive, no-drop, backpressure enable bits
// RULE_08: those three bits clear after reset
// RULE_09: broadcast goes to all ports but source
// RULE_10: option counts multicast in storm control
// RULE_11: global threshold, per-port storm enable
// RULE_12: interval 50 ms fast, 500 ms slow
// RULE_13: counter cleared each interval, then counts
// RULE_14: storm threshold resets to 74
// RULE_15: over threshold, drop counted frames till interval
// RULE_16: port default priority in control bit 4
// RULE_17: tag OR code point overrides port priority
// RULE_18: tag classification enabled by bit 5
// RULE_19: base priority in global 0x02 bits 6:4
// RULE_20: tagged frame priority compared against base
// RULE_21: field at or above base is high
// RULE_22: code point indexes 64-bit mask, one high
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// per-port mac control for a five-port switch
// ----------------------------------------------------------------------
// register map, one byte per word index (haddr[9:2]):
//   0x02 bits 6:4  base priority for tag classification
//   0x03 bit 0     aggressive backoff
//   0x04 bit 3     keep frames after excessive collisions
//   0x04 bit 5     half-duplex backpressure enable
//   0x04 bit 6     multicast counts toward storm limit
//   0x06 bits 2:0  storm threshold, upper bits
//   0x07           storm threshold, lower byte
//   0x10*n         port n control, n = 1..5
//   0x10*n + 0x0E  port n status, bit 0 = storm limit hit
//   0x60..0x67     code-point mask, 0x67 bit 0 is point 0
// port control byte:
//   bit 7 storm enable, bit 6 code point, bit 5 tag,
//   bit 4 default priority, bit 2 speed 100, bit 1 half duplex
// values after reset:
//   global controls all clear, so the lossless bits start off
//   storm threshold 0x04A, every port at 100 Mb/s full duplex
//   code-point mask clear, so code points classify low
// backpressure:
//   a half-duplex port under resource pressure sends preamble,
//   breaks it with a short silence, and yields to its own frames
//   a collision restarts the carrier at once, with no backoff
// limitations:
//   - only the low byte of each word is used; the rest reads zero
//   - the bus never inserts wait states, so writes land one
//     cycle after their address phase
//   - the storm counter counts frames, not bytes, and saturates
//   - interval lengths are parameters so a bench can shorten them

module pbs_port_ctrl
  import pbs_pkg::*;
#(
  parameter int IVL_FAST = IVL_FAST_CYC,
  parameter int IVL_SLOW = IVL_SLOW_CYC,
  parameter int CRS_ON = CRS_ON_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NPORT-1:0] flow_ctrl_req,
  input wire logic [NPORT-1:0] tx_pending,
  input wire logic [NPORT-1:0] col_det,
  input wire logic [NPORT-1:0] rx_frame_valid,
  input wire logic [NPORT-1:0] rx_bcast,
  input wire logic [NPORT-1:0] rx_mcast,
  input wire logic [NPORT-1:0] rx_tagged,
  input wire logic [NPORT-1:0] rx_ipv4,
  input wire logic [3*NPORT-1:0] rx_tag_prio,
  input wire logic [6*NPORT-1:0] rx_dscp,
  output logic [NPORT-1:0] bp_preamble_en,
  output logic [NPORT-1:0] tx_grant,
  output logic [NPORT-1:0] pause_tx_req,
  output logic [NPORT-1:0] rx_drop,
  output logic [NPORT-1:0] rx_high_prio,
  output logic [NPORT*NPORT-1:0] rx_fwd_mask,
  output logic aggr_backoff,
  output logic no_excess_col_drop
);

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  logic [7:0] g2_reg, g3_reg, g4_reg, s6_reg, s7_reg;
  logic [7:0] pctrl_reg [NPORT];
  logic [63:0] cp_mask_reg;
  logic [NPORT-1:0] storm_hit_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [31:0] hrdata_reg;

  wire logic take = hsel && hready && htrans[1];
  wire logic [7:0] a_idx = haddr[9:2];
  wire logic [10:0] storm_thr = {s6_reg[2:0], s7_reg};
  wire logic bp_on = g4_reg[G4_BP_BIT]; // [RULE_07]
  wire logic mc_on = g4_reg[G4_MCAST_BIT]; // [RULE_10]
  wire logic [2:0] base_prio = g2_reg[G2_BASE_LSB +: 3]; // [RULE_19]


  // the mux looks at the address phase, so the read byte is
  // captured together with the transfer and not a cycle later;
  // unmapped indices fall through to zero
  // read mux: ports live at 0x10*n, status byte at +0x0E
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (a_idx == IDX_GCTRL2) begin
      rd_byte = g2_reg;
    end else if (a_idx == IDX_GCTRL3) begin
      rd_byte = g3_reg;
    end else if (a_idx == IDX_GCTRL4) begin
      rd_byte = g4_reg;
    end else if (a_idx == IDX_STORM6) begin
      rd_byte = s6_reg;
    end else if (a_idx == IDX_STORM7) begin
      rd_byte = s7_reg;
    end else if (a_idx >= IDX_CP_FIRST && a_idx <= IDX_CP_LAST) begin
      rd_byte = cp_mask_reg[8*(IDX_CP_LAST - a_idx) +: 8];
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (a_idx == IDX_PORT_BASE + 8'(p) * IDX_PORT_STEP) begin
          rd_byte = pctrl_reg[p];
        end else if (a_idx == IDX_PORT_BASE + 8'(p) * IDX_PORT_STEP
                     + IDX_PSTAT_OFS) begin
          rd_byte = {7'h00, storm_hit_reg[p]};
        end
      end
    end
  end


  // the write index is kept from the address phase because the
  // write data only arrives in the following data phase;
  // a read answer stands on hrdata until the next read,
  // which lets software poll status without a hold register
  // zero-wait slave: data phase always ready, response always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_idx_reg <= a_idx;
      end
      if (take && !hwrite) begin
        hrdata_reg <= {24'h000000, rd_byte};
      end
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;


  // only the low byte is stored; writes to unmapped or
  // read-only indices are dropped without an error response
  // register writes; the lossless bits come up cleared [RULE_08]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g2_reg <= G2_RST;
      g3_reg <= G3_RST;
      g4_reg <= G4_RST;
      s6_reg <= {5'h00, STORM_RST[10:8]}; // [RULE_14]
      s7_reg <= STORM_RST[7:0]; // [RULE_14]
      cp_mask_reg <= 64'h0;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == IDX_GCTRL2) g2_reg <= hwdata[7:0];
      else if (wr_idx_reg == IDX_GCTRL3) g3_reg <= hwdata[7:0];
      else if (wr_idx_reg == IDX_GCTRL4) g4_reg <= hwdata[7:0];
      else if (wr_idx_reg == IDX_STORM6) s6_reg <= hwdata[7:0];
      else if (wr_idx_reg == IDX_STORM7) s7_reg <= hwdata[7:0];
      else if (wr_idx_reg >= IDX_CP_FIRST && wr_idx_reg <= IDX_CP_LAST)
        cp_mask_reg[8*(IDX_CP_LAST - wr_idx_reg) +: 8] <= hwdata[7:0];
    end
  end


  // the mac sees these one cycle after the write lands,
  // which is harmless because it only reads them per frame
  // mac config straight from registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aggr_backoff <= 1'b0;
      no_excess_col_drop <= 1'b0;
    end else begin
      aggr_backoff <= g3_reg[G3_AGGR_BIT]; // [RULE_07]
      no_excess_col_drop <= g4_reg[G4_NODROP_BIT]; // [RULE_07]
    end
  end

  // ----------------------------------------------------------------------
  // per-port logic
  // ----------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      pbs_state_t st_reg, st_next;
      logic [31:0] crs_cnt_reg;
      logic [31:0] ivl_cnt_reg;
      logic [10:0] storm_cnt_reg;
      wire logic [7:0] pc = pctrl_reg[gp];
      wire logic half = pc[P_HALF_BIT];
      // same resource condition drives pause and backpressure [RULE_01]
      wire logic need_bp = flow_ctrl_req[gp] && half && bp_on;
      wire logic crs_done = crs_cnt_reg >= 32'(CRS_ON - 1);
      wire logic gap_done = crs_cnt_reg >= 32'(CRS_GAP_CYC - 1);
      wire logic [31:0] ivl_len = pc[P_FAST_BIT] ? 32'(IVL_FAST)
                                                 : 32'(IVL_SLOW); // [RULE_12]
      wire logic ivl_end = ivl_cnt_reg >= ivl_len - 32'd1;
      wire logic counted = rx_frame_valid[gp] &&
                           (rx_bcast[gp] || (mc_on && rx_mcast[gp])); // [RULE_10]
      wire logic over = pc[P_STORM_BIT] &&
                        (storm_cnt_reg >= storm_thr); // [RULE_11]
      wire logic drop_now = counted && over; // [RULE_15]
      wire logic tag_hi = rx_tagged[gp] &&
                          (rx_tag_prio[3*gp +: 3] >= base_prio); // [RULE_20] [RULE_21]
      wire logic cp_hi = rx_ipv4[gp] &&
                         cp_mask_reg[rx_dscp[6*gp +: 6]]; // [RULE_22]
      logic prio_hi;


      // priority order: tag and code point together give their OR;
      // one of them alone decides only for frames it can read;
      // everything else falls back to the port default, unless both are enabled
      // classification: tag/code point results override port default
      always_comb begin
        prio_hi = pc[P_PRIO_BIT]; // [RULE_16]
        if (pc[P_TAG_BIT] && pc[P_CP_BIT]) begin
          prio_hi = tag_hi || cp_hi; // [RULE_17]
        end else if (pc[P_TAG_BIT] && rx_tagged[gp]) begin
          prio_hi = tag_hi; // [RULE_18]
        end else if (pc[P_CP_BIT] && rx_ipv4[gp]) begin
          prio_hi = cp_hi;
        end
      end


      // states:
      //   idle - no backpressure needed, port behaves normally
      //   jam  - preamble on the wire so stations defer
      //   gap  - short silence so no station sees jabber
      //   send - own queued frames go out instead of preamble
      // the gap is far shorter than an interframe gap, so no
      // station can start a frame before carrier returns
      // backpressure sequencer
      always_comb begin
        st_next = st_reg;
        case (st_reg)
          PBS_IDLE: begin
            if (need_bp && tx_pending[gp]) st_next = PBS_SEND;
            else if (need_bp) st_next = PBS_JAM; // [RULE_02]
          end
          PBS_JAM: begin
            if (!need_bp) st_next = PBS_IDLE;
            else if (tx_pending[gp]) st_next = PBS_SEND; // [RULE_04]
            else if (col_det[gp]) st_next = PBS_JAM; // [RULE_06]
            else if (crs_done) st_next = PBS_GAP; // [RULE_03]
          end
          PBS_GAP: begin
            if (!need_bp) st_next = PBS_IDLE;
            else if (tx_pending[gp]) st_next = PBS_SEND;
            else if (gap_done || col_det[gp]) st_next = PBS_JAM; // [RULE_03] [RULE_06]
          end
          PBS_SEND: begin
            if (!tx_pending[gp]) begin
              st_next = need_bp ? PBS_JAM : PBS_IDLE; // [RULE_05]
            end
          end
          default: st_next = PBS_IDLE;
        endcase
      end

      // a collision restarts the carrier window rather than backing off
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_reg <= PBS_IDLE;
          crs_cnt_reg <= 32'd0;
        end else begin
          st_reg <= st_next;
          if (st_next != st_reg || col_det[gp]) crs_cnt_reg <= 32'd0; // [RULE_06]
          else crs_cnt_reg <= crs_cnt_reg + 32'd1;
        end
      end

      // storm interval: clear at start, count within [RULE_13]
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ivl_cnt_reg <= 32'd0;
          storm_cnt_reg <= 11'd0;
        end else if (ivl_end) begin
          ivl_cnt_reg <= 32'd0;
          // a frame on the boundary opens the new count, not lost
          storm_cnt_reg <= 11'(counted); // [RULE_13]
        end else begin
          ivl_cnt_reg <= ivl_cnt_reg + 32'd1;
          if (counted && storm_cnt_reg != 11'h7FF)
            storm_cnt_reg <= storm_cnt_reg + 11'd1;
        end
      end


      // every port output is a flop so downstream timing is clean;
      // the frame results stand for one cycle after the frame
      // registered port outputs
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          bp_preamble_en[gp] <= 1'b0;
          tx_grant[gp] <= 1'b0;
          pause_tx_req[gp] <= 1'b0;
          rx_drop[gp] <= 1'b0;
          rx_high_prio[gp] <= 1'b0;
          rx_fwd_mask[NPORT*gp +: NPORT] <= '0;
          storm_hit_reg[gp] <= 1'b0;
        end else begin
          bp_preamble_en[gp] <= (st_next == PBS_JAM); // [RULE_02]
          tx_grant[gp] <= tx_pending[gp] &&
                          (!need_bp || st_next == PBS_SEND); // [RULE_04]
          pause_tx_req[gp] <= flow_ctrl_req[gp] && !half; // [RULE_01]
          rx_drop[gp] <= drop_now; // [RULE_15]
          rx_high_prio[gp] <= rx_frame_valid[gp] && prio_hi;
          rx_fwd_mask[NPORT*gp +: NPORT] <=
            (rx_frame_valid[gp] && rx_bcast[gp] && !drop_now)
              ? ~(NPORT'(1) << gp) : '0; // [RULE_09]
          storm_hit_reg[gp] <= over;
        end
      end
    end
  endgenerate


  // kept apart from the per-port logic so the bus decode stays
  // in one place; the reset value selects 100 Mb/s full duplex
  // port control registers, one per port
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_pctrl
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pctrl_reg[gp] <= PCTRL_RST;
        end else if (wr_pend_reg &&
                     wr_idx_reg == IDX_PORT_BASE + 8'(gp) * IDX_PORT_STEP) begin
          pctrl_reg[gp] <= hwdata[7:0];
        end
      end
    end
  endgenerate

endmodule : pbs_port_ctrl
`default_nettype wire

//--- tb/pbs_port_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port control checker
// ----------------------------------------
module pbs_port_ctrl_chk
  import pbs_pkg::*;
#(
  parameter int CRS_ON = CRS_ON_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NPORT-1:0] flow_ctrl_req,
  input wire logic [NPORT-1:0] tx_pending,
  input wire logic [NPORT-1:0] col_det,
  input wire logic [NPORT-1:0] rx_frame_valid,
  input wire logic [NPORT-1:0] rx_bcast,
  input wire logic [NPORT-1:0] bp_preamble_en,
  input wire logic [NPORT-1:0] tx_grant,
  input wire logic [NPORT-1:0] pause_tx_req,
  input wire logic [NPORT-1:0] rx_drop,
  input wire logic [NPORT-1:0] rx_high_prio,
  input wire logic [NPORT*NPORT-1:0] rx_fwd_mask
);
  int on_cnt_reg;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // burst length on port 0; too long a burst looks like jabber
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt_reg <= 0;
    end else begin
      on_cnt_reg <= bp_preamble_en[0] ? on_cnt_reg + 1 : 0;
    end
  end
  a_jam_bounded:
    assert property (on_cnt_reg <= CRS_ON) else $error("burst too long");
  a_gap_regen:
    assert property ($fell(bp_preamble_en[0]) && flow_ctrl_req[0]
      && !tx_pending[0] |-> ##[1:10] (bp_preamble_en[0]
      || !flow_ctrl_req[0] || tx_pending[0])) else $error("no regen");
  a_col_regen:
    assert property ($rose(col_det[0]) && flow_ctrl_req[0] && !tx_pending[0]
      && $past(bp_preamble_en[0], 3) |-> ##[1:3] bp_preamble_en[0])
      else $error("late carrier after collision");
  a_bp_cause:
    assert property ($rose(bp_preamble_en[0]) |-> $past(flow_ctrl_req[0]))
      else $error("carrier without need");
  a_pause_cause:
    assert property ($rose(pause_tx_req[1]) |-> $past(flow_ctrl_req[1]))
      else $error("pause without need");
  a_duplex_excl:
    assert property ((bp_preamble_en & pause_tx_req) == '0)
      else $error("carrier and pause together");
  a_grant_quiet:
    assert property ((tx_grant & bp_preamble_en) == '0)
      else $error("carrier during send");
  a_bcast_mask:
    assert property (rx_frame_valid[2] && rx_bcast[2] |=> rx_drop[2]
      || rx_fwd_mask[14:10] == 5'h1B) else $error("bad forward mask");
  a_drop_cause:
    assert property (rx_drop[2] |-> $past(rx_frame_valid[2]))
      else $error("drop without frame");
  a_prio_cause:
    assert property (rx_high_prio[4] |-> $past(rx_frame_valid[4]))
      else $error("priority without frame");
  c_bp: cover property ($rose(bp_preamble_en[0]));
  c_grant: cover property (tx_grant[0]);
  c_drop: cover property (rx_drop[2]);
  c_prio: cover property (rx_high_prio[4]);
endmodule : pbs_port_ctrl_chk
bind pbs_port_ctrl pbs_port_ctrl_chk #(.CRS_ON(CRS_ON)) u_chk (
  .hclk, .hresetn, .flow_ctrl_req, .tx_pending, .col_det, .rx_frame_valid,
  .rx_bcast, .bp_preamble_en, .tx_grant, .pause_tx_req, .rx_drop,
  .rx_high_prio, .rx_fwd_mask
);
`default_nettype wire

//--- tb/pbs_station.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// remote stations on the port segments
// ----------------------------------------
module pbs_station
  import pbs_pkg::*;
(
  input wire logic hclk,
  input wire logic [NPORT-1:0] carrier,
  output logic [NPORT-1:0] col_det,
  output logic [NPORT-1:0] rx_frame_valid,
  output logic [NPORT-1:0] rx_bcast,
  output logic [NPORT-1:0] rx_mcast,
  output logic [NPORT-1:0] rx_tagged,
  output logic [NPORT-1:0] rx_ipv4,
  output logic [3*NPORT-1:0] rx_tag_prio,
  output logic [6*NPORT-1:0] rx_dscp
);
  initial begin
    {col_det, rx_frame_valid, rx_bcast, rx_mcast, rx_tagged, rx_ipv4} = '0;
    {rx_tag_prio, rx_dscp} = '0;
  end
  // a station defers while it senses carrier, then sends one frame;
  // qualifiers are inverted after it so stale values are never trusted
  task send(input int p, input logic [12:0] f);
    int k;
    k = 0;
    while (carrier[p] === 1'b1 && k < 100) begin
      @(posedge hclk);
      k++;
    end
    @(posedge hclk);
    rx_frame_valid[p] <= 1'b1;
    {rx_bcast[p], rx_mcast[p], rx_tagged[p], rx_ipv4[p]} <= f[12:9];
    rx_tag_prio[3*p +: 3] <= f[8:6];
    rx_dscp[6*p +: 6] <= f[5:0];
    @(posedge hclk);
    rx_frame_valid[p] <= 1'b0;
    {rx_bcast, rx_mcast, rx_tagged} <= ~{rx_bcast, rx_mcast, rx_tagged};
    {rx_ipv4, rx_tag_prio, rx_dscp} <= ~{rx_ipv4, rx_tag_prio, rx_dscp};
  endtask : send
  // a station talking into our carrier makes a one-cycle collision
  task collide(input int p);
    @(posedge hclk);
    col_det[p] <= 1'b1;
    @(posedge hclk);
    col_det[p] <= 1'b0;
  endtask : collide
endmodule : pbs_station
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port control testbench
// ----------------------------------------
module testbench
  import pbs_pkg::*;
;
  localparam int T_CRS = 20;
  localparam logic [12:0] BC = 13'h1000;
  localparam logic [12:0] MC = 13'h0800;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic aggr_backoff, no_excess_col_drop;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NPORT-1:0] flow_ctrl_req, tx_pending, col_det, rx_frame_valid;
  logic [NPORT-1:0] rx_bcast, rx_mcast, rx_tagged, rx_ipv4, bp_preamble_en;
  logic [NPORT-1:0] tx_grant, pause_tx_req, rx_drop, rx_high_prio;
  logic [3*NPORT-1:0] rx_tag_prio;
  logic [6*NPORT-1:0] rx_dscp;
  logic [NPORT*NPORT-1:0] rx_fwd_mask;
  int n_fail = 0;
  int check_count = 0;
  int n;
  time t0;
  logic [7:0] ri [7] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h10, 8'h0C};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h4A, 8'h04, 8'h00};
  logic [7:0] cc [10] = '{8'h14, 8'h04, 8'h24, 8'h24, 8'h24, 8'h44, 8'h44,
    8'h44, 8'h74, 8'h74};
  logic [12:0] ff [10] = '{13'h0, 13'h0, 13'h480, 13'h4C0, 13'h5C0, 13'h200,
    13'h201, 13'h23F, 13'h681, 13'h680};
  logic [0:9] ee = 10'b1001110101;
  pbs_port_ctrl #(.IVL_FAST(200), .IVL_SLOW(2000), .CRS_ON(T_CRS)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .flow_ctrl_req,
    .tx_pending, .col_det, .rx_frame_valid, .rx_bcast, .rx_mcast, .rx_tagged,
    .rx_ipv4, .rx_tag_prio, .rx_dscp, .bp_preamble_en, .tx_grant,
    .pause_tx_req, .rx_drop, .rx_high_prio, .rx_fwd_mask, .aggr_backoff,
    .no_excess_col_drop
  );
  pbs_station st (
    .hclk, .carrier(bp_preamble_en), .col_det, .rx_frame_valid, .rx_bcast,
    .rx_mcast, .rx_tagged, .rx_ipv4, .rx_tag_prio, .rx_dscp
  );
  always #10 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one bus phase; the bench never assumes how soon the slave answers
  task automatic ph;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
  endtask : ph
  task automatic acc(input logic [7:0] i, input logic w, input logic [7:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    ph;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    ph;
    r = hrdata;
  endtask : acc
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    acc(i, 1'b1, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] r;
    acc(i, 1'b0, 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rd
  task automatic fr(input int p, input logic [12:0] f, input logic [1:0] e);
    st.send(p, f);
    #1;
    chk(32'({rx_drop[p], rx_high_prio[p]}), 32'(e));
  endtask : fr
  // samples port 0 carrier after each edge while it stays at level v
  task automatic run(input logic v, output int c);
    c = 0;
    while (bp_preamble_en[0] === v && c < 200) begin
      @(posedge hclk);
      #1;
      c++;
    end
  endtask : run
  // polls the port 3 storm status until a new interval has begun
  task automatic wait_clr;
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      acc(8'h3E, 1'b0, 8'h00, r);
      k++;
    end while (r[0] !== 1'b0 && k < 200);
  endtask : wait_clr
  task automatic summarize;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    summarize;
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {flow_ctrl_req, tx_pending} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ri[i], rv[i]);
    end
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    $display("test registers done");
    wr(8'h10, 8'h06);
    wr(8'h20, 8'h04);
    flow_ctrl_req <= 5'h03;
    repeat (10) @(posedge hclk);
    #1;
    chk(32'(bp_preamble_en), 32'h00);
    chk(32'(pause_tx_req), 32'h02);
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h28);
    rd(8'h04, 8'h28);
    chk(32'({aggr_backoff, no_excess_col_drop}), 32'h3);
    run(1'b1, n);
    run(1'b0, n);
    run(1'b1, n);
    chk(32'(n), 32'(T_CRS));
    run(1'b0, n);
    chk(32'(n), 32'(CRS_GAP_CYC));
    @(posedge hclk);
    tx_pending <= 5'h01;
    repeat (3) @(posedge hclk);
    #1;
    chk(32'({tx_grant[0], bp_preamble_en[0]}), 32'h2);
    @(posedge hclk);
    tx_pending <= 5'h00;
    repeat (12) @(posedge hclk);
    #1;
    chk(32'(bp_preamble_en[0]), 32'h1);
    run(1'b1, n);
    st.collide(0);
    @(posedge hclk);
    #1;
    chk(32'(bp_preamble_en[0]), 32'h1);
    @(posedge hclk);
    flow_ctrl_req <= 5'h00;
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(bp_preamble_en | pause_tx_req), 32'h0);
    $display("test backpressure done");
    wr(8'h07, 8'h03);
    wr(8'h06, 8'h00);
    wr(8'h30, 8'h84);
    repeat (4) st.send(2, BC);
    wait_clr;
    t0 = $time;
    for (int i = 0; i < 5; i++) begin
      fr(2, BC, {i >= 3, 1'b0});
      if (i == 0) chk(32'(rx_fwd_mask[14:10]), 32'h1B);
    end
    fr(2, MC, 2'b00);
    wr(8'h04, 8'h68);
    fr(2, MC, 2'b10);
    fr(3, BC, 2'b00);
    wait_clr;
    n = int'(($time - t0) / 20);
    chk(32'(n > 195 && n < 205), 32'h1);
    fr(2, BC, 2'b00);
    $display("test storm done");
    wr(8'h02, 8'h30);
    wr(8'h67, 8'h01);
    wr(8'h60, 8'h80);
    for (int i = 0; i < 10; i++) begin
      wr(8'h50, cc[i]);
      fr(4, ff[i], {1'b0, ee[i]});
    end
    $display("test priority done");
    summarize;
  end
endmodule : testbench
`default_nettype wire
